// ### msm_pkg.sv
/*
  Constants, types and carriers for the mode-select and memory-map block.
  Assumes a single 125 MHz APB clock domain and active-low asynchronous reset.
*/
// Function
// - Operating mode comes from the two mode pins during reset.
// - Single-chip mode has no external bus; ports B, C, F are GPIO.
// - Expanded mode addresses a 64-Kbyte space of on-chip and external locations.
// - Expanded mode drives address high on port B, low on F, data on C.
// - Read/write strobe gives each port C transfer direction; external parts follow it.
// - Test mode is expanded-like and may program configuration byte and calibration data.
// - Bootstrap mode maps the boot ROM; vectors come from its top region.
// - Boot ROM claims the whole 256-byte page at its base.
// - Loader takes up to 1024 bytes, jumps to RAM start on idle or last byte.
// - Loader sets port D wired-OR; transmit pin needs an external pull-up.
// - In bootstrap mode the interrupt vectors point into RAM.
// - Register block sits at its default base; software may move it per page.
// - RAM sits at zero after reset; software may move it per page.
// - Registers win over RAM when both share one page.
// - EEPROM sits at top of memory after reset when the configuration enables it.
// - Expanded and test modes place EEPROM at the configured page.
// - Single-chip and bootstrap modes force EEPROM on at its default place.
// - The configuration byte lives in its own nonvolatile cell.
// - RAM and register block sit at the same addresses in every mode.
// - RAM base page equals the RAM page field.
// - Register block base page equals the register page field.
// - Test mode starts with EEPROM disabled.
// - Normal modes keep the boot ROM out of the map.
package msm_pkg;

  typedef enum logic [1:0] {
    MODE_BOOT   = 2'h0,
    MODE_TEST   = 2'h1,
    MODE_SINGLE = 2'h2,
    MODE_EXP    = 2'h3
  } msm_mode_t;

  typedef enum logic [1:0] {
    BL_IDLE = 2'h0,
    BL_LOAD = 2'h1,
    BL_DONE = 2'h3
  } msm_bl_state_t;

  typedef enum logic [2:0] {
    RG_NONE   = 3'h0,
    RG_REGS   = 3'h1,
    RG_RAM    = 3'h2,
    RG_EEPROM = 3'h3,
    RG_BOOT   = 3'h4,
    RG_EXT    = 3'h5
  } msm_region_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } msm_cpu_req_t;

  typedef struct packed {
    logic [7:0] port_b;
    logic [7:0] port_f;
    logic [7:0] port_c;
    logic [7:0] port_c_oe_n;
    logic       rw;
  } msm_pins_t;

  localparam logic [11:0] OFS_MAP      = 12'h000;
  localparam logic [11:0] OFS_CFG      = 12'h004;
  localparam logic [11:0] OFS_STAT     = 12'h008;
  localparam logic [11:0] OFS_PROBE    = 12'h00c;
  localparam logic [11:0] OFS_CAL      = 12'h010;
  localparam logic [11:0] OFS_GPIO     = 12'h014;
  localparam logic [11:0] OFS_TEST_CTL = 12'h018;

  localparam int          MAP_REG_LSB  = 0;
  localparam int          MAP_RAM_LSB  = 4;
  localparam int          CFG_EN_BIT   = 0;
  localparam int          CFG_PAGE_LSB = 4;
  localparam int          GPIO_B_LSB   = 0;
  localparam int          GPIO_F_LSB   = 8;
  localparam int          GPIO_C_LSB   = 16;
  localparam int          GPIO_DIR_LSB = 24;

  localparam logic [3:0]  RST_REG_PAGE = 4'h1;
  localparam logic [3:0]  RST_RAM_PAGE = 4'h0;
  localparam logic [3:0]  DEF_EE_PAGE  = 4'hf;
  localparam logic [7:0]  CFG_NV_RESET = 8'hf1;
  localparam logic [11:0] REG_BYTES    = 12'h060;
  localparam logic [1:0]  RAM_HI_BITS  = 2'h0;
  localparam logic [2:0]  EE_HI_BITS   = 3'h7;
  localparam logic [7:0]  BOOT_PAGE    = 8'hbf;
  localparam logic [9:0]  RAM_LAST     = 10'h3ff;
  localparam logic [15:0] RAM_START    = 16'h0000;
  localparam logic [1:0]  LATCH_AT     = 2'h2;
  localparam logic [1:0]  EXT_CYCLES   = 2'h3;

endpackage

// ### msm_top.sv
/*
  Operating-mode latch, on-chip memory-map decoder, expansion-bus driver and
  bootstrap download engine, with an APB register file.
  Assumes mode pins and port C input are asynchronous; CPU request and serial
  receive strobes come from logic on pclk.
*/
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module msm_top
  import msm_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = 40000
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         mode_sel_hi,
  input  wire logic         mode_sel_lo,
  output msm_mode_t         mode,
  input  msm_cpu_req_t      cpu_req,
  output logic              cpu_ack,
  output msm_region_t       cpu_region,
  output logic      [7:0]   cpu_rdata,
  output msm_pins_t         pins,
  input  wire logic [7:0]   port_c_in,
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_data,
  output logic              sci_en,
  output logic              portd_wired_or,
  output logic              vec_in_ram,
  output logic              ram_wr,
  output logic      [9:0]   ram_waddr,
  output logic      [7:0]   ram_wdata,
  output logic              boot_jump,
  output logic      [15:0]  boot_jump_addr
);

  // Idle timeout stands in for the four-character gap on the serial line
  localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);

  logic [1:0]        mode_s1_ff, mode_s2_ff;
  logic [1:0]        latch_cnt_ff;
  logic              mode_ok_ff;
  msm_mode_t         mode_ff;
  logic [7:0]        pc_s1_ff, pc_s2_ff;
  logic [7:0]        map_ff, cfg_nv_ff, cal_ff;
  logic              test_ee_on_ff;
  logic [31:0]       gpio_ff;
  logic [15:0]       probe_ff;
  logic              pready_ff, pslverr_ff;
  logic [31:0]       prdata_ff;
  logic              busy_ff, ack_ff, rd_ff;
  logic [1:0]        ext_cnt_ff;
  msm_region_t       region_ff;
  logic [7:0]        rdata_ff;
  msm_pins_t         pins_ff;
  msm_bl_state_t     bl_state_ff;
  logic [9:0]        bl_cnt_ff;
  logic [IDLE_W-1:0] idle_ff;
  logic              sci_en_ff, wor_ff, vec_ff, ram_wr_ff, jump_ff;
  logic [9:0]        ram_waddr_ff;
  logic [7:0]        ram_wdata_ff;
  logic [15:0]       jump_addr_ff;

  logic              is_exp, is_boot, is_test, ee_en;
  logic [3:0]        ee_page, reg_page, ram_page;
  msm_region_t       req_region, probe_region;
  logic [31:0]       rd_val;
  logic              addr_ok, wr_ok, apb_setup, wr_fire, ext_done;

  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s1_ff <= 2'h0;
      mode_s2_ff <= 2'h0;
      pc_s1_ff   <= 8'h00;
      pc_s2_ff   <= 8'h00;
    end else begin
      mode_s1_ff <= {mode_sel_hi, mode_sel_lo};
      mode_s2_ff <= mode_s1_ff;
      pc_s1_ff   <= port_c_in;
      pc_s2_ff   <= pc_s1_ff;
    end
  end

  // Capture once the synchroniser has seen the post-reset level; later pin
  // changes cannot alter the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_cnt_ff <= 2'h0;
      mode_ok_ff   <= 1'b0;
      mode_ff      <= MODE_SINGLE;
    end else if (!mode_ok_ff) begin
      if (latch_cnt_ff == LATCH_AT) begin
        mode_ff    <= msm_mode_t'(mode_s2_ff);
        mode_ok_ff <= 1'b1;
      end else begin
        latch_cnt_ff <= latch_cnt_ff + 2'h1;
      end
    end
  end

  // Test mode decodes as expanded mode apart from its extra EEPROM switch
  assign is_exp   = (mode_ff == MODE_EXP) || (mode_ff == MODE_TEST);
  assign is_test  = (mode_ff == MODE_TEST);
  assign is_boot  = (mode_ff == MODE_BOOT) && mode_ok_ff;
  assign reg_page = map_ff[MAP_REG_LSB +: 4];
  assign ram_page = map_ff[MAP_RAM_LSB +: 4];

  // Test mode additionally needs its own enable, which resets off
  assign ee_en   = is_exp ? (cfg_nv_ff[CFG_EN_BIT] && (!is_test || test_ee_on_ff))
                          : 1'b1;
  assign ee_page = is_exp ? cfg_nv_ff[CFG_PAGE_LSB +: 4] : DEF_EE_PAGE;

  // Mode only decides boot ROM, EEPROM placement and what is left over;
  // on-chip regions otherwise decode alike in all modes
  function automatic msm_region_t decode(input logic [15:0] a);
    if (a[15:12] == reg_page && a[11:0] < REG_BYTES)
      return RG_REGS;
    // Boot ROM claims its whole page even where no code lives
    else if (is_boot && a[15:8] == BOOT_PAGE)
      return RG_BOOT;
    else if (ee_en && a[15:12] == ee_page && a[11:9] == EE_HI_BITS)
      return RG_EEPROM;
    else if (a[15:12] == ram_page && a[11:10] == RAM_HI_BITS)
      return RG_RAM;
    else if (is_exp)
      return RG_EXT;
    else
      return RG_NONE;
  endfunction

  always_comb begin
    req_region   = decode(cpu_req.addr);
    probe_region = decode(probe_ff);
  end

  // APB: setup cycle registers the answer, access phase always one cycle
  assign apb_setup = psel && !penable;
  assign wr_fire   = psel && penable && pready_ff && pwrite && wr_ok;

  // Unknown offsets answer with an error instead of aliasing a register
  always_comb begin
    rd_val  = 32'h0000_0000;
    addr_ok = 1'b1;
    wr_ok   = 1'b1;
    unique case (paddr)
      OFS_MAP:      rd_val = {24'h00_0000, map_ff};
      OFS_CFG: begin
        rd_val = {24'h00_0000, cfg_nv_ff};
        wr_ok  = is_test;
      end
      OFS_STAT: begin
        rd_val = {16'h0000, wor_ff, vec_ff, bl_state_ff, ee_page,
                  3'h0, ee_en, is_boot, mode_ok_ff, mode_ff};
        wr_ok  = 1'b0;
      end
      OFS_PROBE:    rd_val = {13'h0000, probe_region, probe_ff};
      OFS_CAL: begin
        rd_val = {24'h00_0000, cal_ff};
        wr_ok  = is_test;
      end
      OFS_GPIO:     rd_val = {gpio_ff[GPIO_DIR_LSB +: 8], pc_s2_ff, gpio_ff[GPIO_F_LSB +: 8],
                              gpio_ff[GPIO_B_LSB +: 8]};
      OFS_TEST_CTL: begin
        rd_val = {31'h0000_0000, test_ee_on_ff};
        wr_ok  = is_test;
      end
      default:      addr_ok = 1'b0;
    endcase
  end

  // prdata and pslverr hold until the next setup, so a slow master still sees them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff <= apb_setup;
      if (apb_setup) begin
        prdata_ff  <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_val;
        pslverr_ff <= !addr_ok || (pwrite && !wr_ok);
      end
    end
  end

  // Writes land only at the access edge, where pready is already high;
  // the probe lets software ask the decoder about an address without an access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_ff   <= {RST_RAM_PAGE, RST_REG_PAGE};
      gpio_ff  <= 32'h0000_0000;
      probe_ff <= 16'h0000;
    end else if (wr_fire) begin
      if (paddr == OFS_MAP)
        map_ff <= pwdata[7:0];
      if (paddr == OFS_GPIO)
        gpio_ff <= pwdata;
      if (paddr == OFS_PROBE)
        probe_ff <= pwdata[15:0];
    end
  end

  // Nonvolatile cell: kept apart from the array and from the map register;
  // its reset value stands for the programmed contents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_nv_ff <= CFG_NV_RESET;
    end else if (wr_fire && paddr == OFS_CFG) begin
      cfg_nv_ff <= pwdata[7:0];
    end
  end

  // Calibration and the test-mode EEPROM switch take writes in test mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_ff        <= 8'h00;
      test_ee_on_ff <= 1'b0;
    end else if (wr_fire) begin
      if (paddr == OFS_CAL)
        cal_ff <= pwdata[7:0];
      if (paddr == OFS_TEST_CTL)
        test_ee_on_ff <= pwdata[0];
    end
  end

  // CPU access: on-chip hits answer next cycle, external ones hold the bus
  // External cycles have a fixed length: the far side has no wait input, and
  // a request made while an external cycle runs is dropped, not queued
  assign ext_done = busy_ff && (ext_cnt_ff == EXT_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff    <= 1'b0;
      ack_ff     <= 1'b0;
      rd_ff      <= 1'b0;
      ext_cnt_ff <= 2'h0;
      region_ff  <= RG_NONE;
      rdata_ff   <= 8'h00;
    end else begin
      ack_ff <= 1'b0;
      if (busy_ff) begin
        if (ext_done) begin
          busy_ff  <= 1'b0;
          ack_ff   <= 1'b1;
          rdata_ff <= rd_ff ? pc_s2_ff : 8'h00;
        end else begin
          ext_cnt_ff <= ext_cnt_ff + 2'h1;
        end
      end else if (cpu_req.valid) begin
        region_ff <= req_region;
        rd_ff     <= !cpu_req.wr;
        rdata_ff  <= 8'h00;
        if (req_region == RG_EXT) begin
          busy_ff    <= 1'b1;
          ext_cnt_ff <= 2'h0;
        end else begin
          ack_ff <= 1'b1;
        end
      end
    end
  end

  // Port C is released between cycles so a read never fights the far side
  // Single-chip and bootstrap modes hand ports B, C and F to the GPIO register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_ff <= '{port_b: 8'h00, port_f: 8'h00, port_c: 8'h00, port_c_oe_n: 8'hff, rw: 1'b1};
    end else if (!is_exp) begin
      pins_ff.port_b      <= gpio_ff[GPIO_B_LSB +: 8];
      pins_ff.port_f      <= gpio_ff[GPIO_F_LSB +: 8];
      pins_ff.port_c      <= gpio_ff[GPIO_C_LSB +: 8];
      pins_ff.port_c_oe_n <= ~gpio_ff[GPIO_DIR_LSB +: 8];
      pins_ff.rw          <= 1'b1;
    end else if (!busy_ff && cpu_req.valid && req_region == RG_EXT) begin
      pins_ff.port_b      <= cpu_req.addr[15:8];
      pins_ff.port_f      <= cpu_req.addr[7:0];
      pins_ff.port_c      <= cpu_req.wdata;
      pins_ff.port_c_oe_n <= cpu_req.wr ? 8'h00 : 8'hff;
      pins_ff.rw          <= !cpu_req.wr;
    end else if (ext_done || !busy_ff) begin
      pins_ff.port_c_oe_n <= 8'hff;
      pins_ff.rw          <= 1'b1;
    end
  end

  // Download engine; the idle timeout restarts on every byte
  // The byte for the last RAM address ends the load at once rather than
  // waiting out the idle timeout, so control passes without a dead gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_state_ff  <= BL_IDLE;
      bl_cnt_ff    <= 10'h000;
      idle_ff      <= '0;
      ram_wr_ff    <= 1'b0;
      ram_waddr_ff <= 10'h000;
      ram_wdata_ff <= 8'h00;
      jump_ff      <= 1'b0;
      jump_addr_ff <= RAM_START;
    end else begin
      ram_wr_ff <= 1'b0;
      jump_ff   <= 1'b0;
      unique case (bl_state_ff)
        BL_IDLE: begin
          if (is_boot)
            bl_state_ff <= BL_LOAD;
        end
        BL_LOAD: begin
          if (rx_valid) begin
            ram_wr_ff    <= 1'b1;
            ram_waddr_ff <= bl_cnt_ff;
            ram_wdata_ff <= rx_data;
            bl_cnt_ff    <= bl_cnt_ff + 10'h001;
            idle_ff      <= '0;
            if (bl_cnt_ff == RAM_LAST) begin
              bl_state_ff  <= BL_DONE;
              jump_ff      <= 1'b1;
              jump_addr_ff <= RAM_START;
            end
          end else if (idle_ff == IDLE_W'(IDLE_CYCLES - 1)) begin
            bl_state_ff  <= BL_DONE;
            jump_ff      <= 1'b1;
            jump_addr_ff <= RAM_START;
          end else begin
            idle_ff <= idle_ff + IDLE_W'(1);
          end
        end
        BL_DONE: begin
        end
        default: bl_state_ff <= BL_IDLE;
      endcase
    end
  end

  // Port D wired-OR and RAM vectors are levels that follow the latched mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sci_en_ff <= 1'b0;
      wor_ff    <= 1'b0;
      vec_ff    <= 1'b0;
    end else begin
      sci_en_ff <= (bl_state_ff == BL_LOAD);
      wor_ff    <= is_boot;
      vec_ff    <= is_boot;
    end
  end

  // Every output is a flop; no logic sits between the registers and the ports
  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign mode           = mode_ff;
  assign cpu_ack        = ack_ff;
  assign cpu_region     = region_ff;
  assign cpu_rdata      = rdata_ff;
  assign pins           = pins_ff;
  assign sci_en         = sci_en_ff;
  assign portd_wired_or = wor_ff;
  assign vec_in_ram     = vec_ff;
  assign ram_wr         = ram_wr_ff;
  assign ram_waddr      = ram_waddr_ff;
  assign ram_wdata      = ram_wdata_ff;
  assign boot_jump      = jump_ff;
  assign boot_jump_addr = jump_addr_ff;

endmodule

// ### msm_asserts.sv
/* Port-level checker for msm_top: mode latch, bus direction, loader strobes.
   Assumes it is bound to msm_top and mode pins hold still through reset. */
`timescale 1ns/1ps
module msm_asserts
  import msm_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [11:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       mode_sel_hi,
  input wire logic       mode_sel_lo,
  input wire msm_mode_t  mode,
  input wire msm_pins_t  pins,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       sci_en,
  input wire logic       portd_wired_or,
  input wire logic       vec_in_ram,
  input wire logic       ram_wr,
  input wire logic [7:0] ram_wdata,
  input wire logic       boot_jump,
  input wire logic [15:0] boot_jump_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Edges since reset release, saturating
  logic [2:0] rel_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_ff <= 3'h0;
    end else if (rel_ff != 3'h7) begin
      rel_ff <= rel_ff + 3'h1;
    end
  end

  mode_early_a: assert property (rel_ff <= 3'h2 |-> mode == MODE_SINGLE)
    else $error("mode changed before latch point");
  mode_latch_a: assert property (rel_ff == 3'h6 |-> mode == msm_mode_t'({mode_sel_hi, mode_sel_lo}))
    else $error("latched mode differs from pins");
  mode_hold_a: assert property (rel_ff == 3'h7 |-> $stable(mode))
    else $error("mode moved after latch");
  single_rw_a: assert property (mode == MODE_SINGLE || mode == MODE_BOOT |-> pins.rw)
    else $error("bus write strobe in a single-chip mode");
  wr_drive_a: assert property (!pins.rw |-> pins.port_c_oe_n == 8'h00 && mode inside {MODE_EXP, MODE_TEST})
    else $error("port C not driven during write");
  wr_len_a: assert property ($fell(pins.rw) |-> !pins.rw [*4] ##1 pins.rw)
    else $error("external write strobe length wrong");
  pready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  cfg_guard_a: assert property (psel && !penable && pwrite && paddr == OFS_CFG && mode != MODE_TEST |=> pslverr)
    else $error("config write accepted outside test mode");
  load_wr_a: assert property (rx_valid && sci_en |=> ram_wr && ram_wdata == $past(rx_data))
    else $error("received byte not written to RAM");
  jump_addr_a: assert property (boot_jump |-> boot_jump_addr == RAM_START && mode == MODE_BOOT)
    else $error("jump target wrong");
  boot_pins_a: assert property (portd_wired_or || vec_in_ram || sci_en |-> mode == MODE_BOOT)
    else $error("loader signals outside bootstrap mode");
endmodule

// ### msm_ext_mem.sv
/* Behavioural external memory on the expansion bus.
   Assumes sel is high only in expanded-type modes; lat sets answer delay. */
`timescale 1ns/1ps
module msm_ext_mem
  import msm_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       sel,
  input  wire logic [1:0] lat,
  input  wire msm_pins_t  pins,
  output logic      [7:0] port_c_in
);
  logic [7:0]  mem [256] = '{default: 8'h00};
  logic [7:0]  last = 8'h5a;
  logic [15:0] addr = 16'h0000;
  logic [1:0]  age = 2'h3;
  logic [1:0]  seen;
  always @(posedge pclk) begin
    if (!pins.rw && pins.port_c_oe_n == 8'h00) begin
      mem[pins.port_f] <= pins.port_c;
    end
    addr <= {pins.port_b, pins.port_f};
    age <= ({pins.port_b, pins.port_f} != addr) ? 2'h1 : ((age == 2'h3) ? age : age + 2'h1);
    last <= port_c_in;
  end
  // Edges at which the present address has already stood on the bus
  assign seen = ({pins.port_b, pins.port_f} == addr) ? age : 2'h0;
  // Undriven bus shows a toggling pattern so stale data never looks valid
  assign port_c_in = (sel && pins.rw && seen >= lat) ? mem[pins.port_f] : ~last;
endmodule

// ### msm_top_tb.sv
/* Self-checking bench for msm_top: decode table, register file, loader.
   Assumes msm_ext_mem and msm_asserts are compiled before this file. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
module msm_top_tb
  import msm_pkg::*;
;
  typedef struct {logic [1:0] md; logic wr; logic [15:0] a; logic [7:0] d; msm_region_t rg;} msm_row_t;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, mode_sel_hi, mode_sel_lo;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         cpu_ack, rx_valid, sci_en, portd_wired_or, vec_in_ram, ram_wr, boot_jump, er;
  logic [7:0]   cpu_rdata, port_c_in, rx_data, ram_wdata;
  logic [9:0]   ram_waddr;
  logic [15:0]  boot_jump_addr;
  logic [1:0]   cur_md;
  msm_mode_t    mode;
  msm_region_t  cpu_region;
  msm_cpu_req_t cpu_req;
  msm_pins_t    pins;
  int           err_count, cmp_count;
  msm_row_t     rows [] = '{
    '{2'h2, 1'h0, 16'h1000, 8'h00, RG_REGS}, '{2'h2, 1'h0, 16'h105f, 8'h00, RG_REGS},
    '{2'h2, 1'h0, 16'h1060, 8'h00, RG_NONE}, '{2'h2, 1'h0, 16'h0000, 8'h00, RG_RAM},
    '{2'h2, 1'h0, 16'h03ff, 8'h00, RG_RAM}, '{2'h2, 1'h0, 16'h0400, 8'h00, RG_NONE},
    '{2'h2, 1'h0, 16'hfe00, 8'h00, RG_EEPROM}, '{2'h2, 1'h0, 16'hbf00, 8'h00, RG_NONE},
    '{2'h0, 1'h0, 16'hbf00, 8'h00, RG_BOOT}, '{2'h0, 1'h0, 16'hbfc0, 8'h00, RG_BOOT},
    '{2'h0, 1'h0, 16'hbfff, 8'h00, RG_BOOT}, '{2'h0, 1'h0, 16'hbeff, 8'h00, RG_NONE},
    '{2'h0, 1'h0, 16'hffff, 8'h00, RG_EEPROM}, '{2'h3, 1'h1, 16'h2055, 8'ha5, RG_EXT},
    '{2'h3, 1'h0, 16'h2055, 8'ha5, RG_EXT}, '{2'h3, 1'h1, 16'hc001, 8'h3c, RG_EXT},
    '{2'h3, 1'h0, 16'hc001, 8'h3c, RG_EXT}, '{2'h3, 1'h0, 16'hfe00, 8'h00, RG_EEPROM},
    '{2'h3, 1'h0, 16'h1000, 8'h00, RG_REGS}, '{2'h3, 1'h0, 16'hbf00, 8'h00, RG_EXT},
    '{2'h1, 1'h0, 16'hfe00, 8'h00, RG_EXT}, '{2'h1, 1'h0, 16'h1000, 8'h00, RG_REGS},
    '{2'h1, 1'h0, 16'hc001, 8'h3c, RG_EXT}};

  msm_top #(.IDLE_CYCLES(20)) msm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo), .mode(mode), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
    .cpu_region(cpu_region), .cpu_rdata(cpu_rdata), .pins(pins), .port_c_in(port_c_in), .rx_valid(rx_valid),
    .rx_data(rx_data), .sci_en(sci_en), .portd_wired_or(portd_wired_or), .vec_in_ram(vec_in_ram),
    .ram_wr(ram_wr), .ram_waddr(ram_waddr), .ram_wdata(ram_wdata), .boot_jump(boot_jump),
    .boot_jump_addr(boot_jump_addr));
  // Test mode answers one cycle slower than expanded mode
  msm_ext_mem msm_ext_mem_inst (.pclk(pclk), .sel(mode_sel_lo), .lat({1'b0, ~mode_sel_hi}), .pins(pins),
    .port_c_in(port_c_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wait_hi(ref logic sig, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sig !== 1'b1 && n < lim);
    if (sig !== 1'b1) begin
      err_count++;
      $display("MISMATCH wait exp=1 got=%0b", sig);
      conclude();
    end
  endtask

  task automatic boot_up(input logic [1:0] md);
    presetn <= 1'b0;
    {mode_sel_hi, mode_sel_lo} <= md;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (7) @(posedge pclk);
    `CHK("mode", msm_mode_t'(md), mode)
    cur_md = md;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(pready, 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cpu(input msm_row_t r);
    cpu_req <= '{valid: 1'b1, wr: r.wr, addr: r.a, wdata: r.d};
    @(posedge pclk);
    cpu_req.valid <= 1'b0;
    wait_hi(cpu_ack, 12);
    `CHK("region", r.rg, cpu_region)
    if (r.rg == RG_EXT) `CHK("ext_addr", r.a, ({pins.port_b, pins.port_f}))
    if (!r.wr) `CHK("rdata", r.d, cpu_rdata)
    @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_data} = '0;
    {mode_sel_hi, mode_sel_lo} = 2'h2;
    cpu_req = '0;
    cur_md = 2'bxx;
    foreach (rows[i]) begin
      if (rows[i].md !== cur_md) boot_up(rows[i].md);
      cpu(rows[i]);
    end
    $display("decode table done");
    boot_up(2'h2);
    apb(1'b0, OFS_MAP, 32'h0);
    `CHK("map_reset", 32'h00000001, rd)
    apb(1'b1, OFS_CFG, 32'h0);
    `CHK("cfg_guard", 1'b1, er)
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("cfg_reset", 32'h000000f1, rd)
    apb(1'b1, OFS_MAP, 32'h22);
    apb(1'b0, OFS_MAP, 32'h0);
    `CHK("map", 32'h00000022, rd)
    apb(1'b1, OFS_PROBE, 32'h2000);
    apb(1'b0, OFS_PROBE, 32'h0);
    `CHK("probe", 32'h0001_2000, rd)
    cpu('{2'h2, 1'h0, 16'h2000, 8'h00, RG_REGS});
    cpu('{2'h2, 1'h0, 16'h2060, 8'h00, RG_RAM});
    cpu('{2'h2, 1'h0, 16'h0000, 8'h00, RG_NONE});
    apb(1'b0, 12'h01c, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, OFS_GPIO, 32'h0f33_2211);
    @(posedge pclk);
    `CHK("gpio_pins", 32'hf033_2211, ({pins.port_c_oe_n, pins.port_c, pins.port_f, pins.port_b}))
    $display("remap test done");
    boot_up(2'h1);
    apb(1'b1, OFS_CFG, 32'h31);
    `CHK("cfg_test_wr", 1'b0, er)
    apb(1'b1, OFS_TEST_CTL, 32'h1);
    apb(1'b1, OFS_CAL, 32'h5a);
    `CHK("cal_wr", 1'b0, er)
    apb(1'b0, OFS_CAL, 32'h0);
    `CHK("cal", 32'h0000005a, rd)
    cpu('{2'h1, 1'h0, 16'h3e00, 8'h00, RG_EEPROM});
    cpu('{2'h1, 1'h0, 16'hfe00, 8'h00, RG_EXT});
    {mode_sel_hi, mode_sel_lo} <= 2'h2;
    repeat (6) @(posedge pclk);
    `CHK("mode_hold", MODE_TEST, mode)
    $display("test mode done");
    boot_up(2'h0);
    `CHK("wired_or", 1'b1, portd_wired_or)
    `CHK("vec_ram", 1'b1, vec_in_ram)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("stat", 32'h0000_df1c, rd)
    for (int i = 0; i < 1024; i++) begin
      rx_valid <= 1'b1;
      rx_data <= 8'(i) ^ 8'h5a;
      @(posedge pclk);
      rx_valid <= 1'b0;
      @(posedge pclk);
      `CHK("waddr", 10'(i), ram_waddr)
      if (i == 1023) `CHK("jump_last", 1'b1, boot_jump)
    end
    boot_up(2'h0);
    wait_hi(boot_jump, 40);
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    @(posedge pclk);
    `CHK("late_byte", 1'b0, ram_wr)
    `CHK("sci_off", 1'b0, sci_en)
    $display("loader done");
    conclude();
  end
endmodule

bind msm_top msm_asserts msm_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .mode_sel_hi, .mode_sel_lo, .mode, .pins, .rx_valid, .rx_data, .sci_en, .portd_wired_or, .vec_in_ram,
  .ram_wr, .ram_wdata, .boot_jump, .boot_jump_addr);
